/* File: hw/sbsp_port.sv */
`timescale 1ns/100ps
// Overview of operation
// - Burst step low with both strobes high during an active burst advances the burst counter to the next word.
// - Write data with burst step low is captured and stored on that edge.
// - Read when all byte strobes high or cpu strobe low, else write.
// - Any byte strobe low keeps the data outputs undriven regardless of enable.
// - Internal select is the AND of the three chip selects at active level.
// - A cpu strobe burst start ignores byte strobes and reads first.
// - Selected cpu strobe loads the external address and counter.
// - Cpu strobe with select starts a read and ends any running burst.
// - Selected controller strobe alone starts a write if any byte strobe low, else read.
// - Counter loads at burst start, steps per word, four words on two bits.
// - Step high with both strobes high repeats the access at the same address.
module sbsp_port (
  input  wire logic                         clock_i,
  input  wire logic                         sys_rst_i,
  input  wire logic [sbsp_pkg::ADDR_W-1:0]  addr_i,
  input  wire sbsp_pkg::sbsp_ctl_s          ctl_i,
  input  wire sbsp_pkg::sbsp_sel_s          sel_i,
  input  wire logic                         out_enable_n_i,
  input  wire logic [sbsp_pkg::DATA_W-1:0]  dq_i,
  output logic      [sbsp_pkg::DATA_W-1:0]  dq_o,
  output logic                              dq_oe_o
);
  import sbsp_pkg::*;

  sbsp_state_s        st;
  sbsp_state_s        next_st;
  logic [DATA_W-1:0]  mem [DEPTH];
  logic               selected;
  logic               cpu_begin;
  logic               ctrl_begin;
  logic               deselect;
  logic               cont;
  logic               step;
  logic               load;
  logic               any_wr;
  logic               active;
  sbsp_op_e           op;
  logic [CNT_W-1:0]   cur_lsbs;
  logic [CNT_W-1:0]   next_lsbs;
  logic [CNT_W-1:0]   count;
  logic [ADDR_W-1:0]  op_addr;
  logic [DATA_W-1:0]  wr_word;

  //----------------------------------------------------------------------------
  // Cycle qualification
  //----------------------------------------------------------------------------
  // Combined chip select.
  assign selected   = ~sel_i.chip_select_n & sel_i.chip_select_high_active & ~sel_i.chip_select2_n;
  assign cpu_begin  = ~ctl_i.cpu_addr_strobe_n & selected;
  assign ctrl_begin = ~ctl_i.ctrl_addr_strobe_n & selected & ~cpu_begin;
  assign deselect   = ~ctl_i.ctrl_addr_strobe_n & ~selected;
  assign cont       = ctl_i.ctrl_addr_strobe_n & ~cpu_begin;
  assign any_wr     = ~(&ctl_i.byte_write_strobes_n);
  assign active     = (st.last_op != SBSP_OP_IDLE);
  assign load       = cpu_begin | ctrl_begin;
  assign step       = cont & active & ~ctl_i.burst_step_n;

  always_comb begin
    op = SBSP_OP_IDLE;
    if (cpu_begin) begin
      op = SBSP_OP_READ;
    end else if (ctrl_begin) begin
      op = any_wr ? SBSP_OP_WRITE : SBSP_OP_READ;
    end else if (deselect) begin
      op = SBSP_OP_IDLE;
    end else if (cont & active) begin
      op = (any_wr & ctl_i.cpu_addr_strobe_n) ? SBSP_OP_WRITE : SBSP_OP_READ;
    end
  end

  //----------------------------------------------------------------------------
  // Burst counter
  //----------------------------------------------------------------------------
  // Load and step per word.
  sbsp_burst_ctr u_ctr (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .load_i      (load),
    .step_i      (step),
    .start_i     (addr_i[CNT_W-1:0]),
    .lsbs_o      (cur_lsbs),
    .count_o     (count),
    .next_lsbs_o (next_lsbs)
  );

  assign op_addr = {(load ? addr_i[ADDR_W-1:CNT_W] : st.upper), next_lsbs};

  //----------------------------------------------------------------------------
  // State update
  //----------------------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.last_op = op;
    if (load) begin
      next_st.upper = addr_i[ADDR_W-1:CNT_W];
    end
    case (op)
      SBSP_OP_READ: begin
        // Repeat read at current address when suspended.
        next_st.dq_out = mem[op_addr];
      end
      SBSP_OP_WRITE: begin
        next_st.dq_out = st.dq_out;
      end
      SBSP_OP_IDLE: begin
        next_st.dq_out = st.dq_out;
      end
      default: begin
        next_st.dq_out = st.dq_out;
      end
    endcase
    // Byte strobe low blocks the output drive.
    next_st.dq_oe = (op == SBSP_OP_READ) & ~any_wr & ~out_enable_n_i;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '{upper: UPPER_RST, last_op: SBSP_OP_IDLE, dq_out: DATA_RST, dq_oe: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  //----------------------------------------------------------------------------
  // Array write
  //----------------------------------------------------------------------------
  // Each lane takes new data only when its own strobe is low; the other lanes keep their old bits.
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign wr_word[g*BYTE_W +: BYTE_W] = ctl_i.byte_write_strobes_n[g] ? mem[op_addr][g*BYTE_W +: BYTE_W]
                                                                        : dq_i[g*BYTE_W +: BYTE_W];
  end

  // One process owns the array, so every word has a single driver.
  always_ff @(posedge clock_i) begin
    // Store the word captured on this edge.
    if (op == SBSP_OP_WRITE) begin
      mem[op_addr] <= wr_word;
    end
  end

  assign dq_o    = st.dq_out;
  assign dq_oe_o = st.dq_oe;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  sequence s_cpu_start;
    !ctl_i.cpu_addr_strobe_n && selected;
  endsequence

  sequence s_suspend;
    ctl_i.cpu_addr_strobe_n && ctl_i.ctrl_addr_strobe_n && ctl_i.burst_step_n;
  endsequence

  sequence s_step;
    ctl_i.cpu_addr_strobe_n && ctl_i.ctrl_addr_strobe_n && !ctl_i.burst_step_n;
  endsequence

  a_cpu_start_read: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_cpu_start |=> (st.last_op == SBSP_OP_READ) && (count == CNT_RST))
    else $error("cpu strobe start did not begin a read");

  a_cpu_start_addr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_cpu_start |=> (st.upper == $past(addr_i[ADDR_W-1:CNT_W])) && (cur_lsbs == $past(addr_i[CNT_W-1:0])))
    else $error("cpu strobe start did not load the address");

  a_write_no_drive: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (any_wr ##1 1'b1) |-> !dq_oe_o)
    else $error("data driven while a byte strobe was low");

  a_deselect_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!ctl_i.ctrl_addr_strobe_n && (sel_i.chip_select_n || !sel_i.chip_select_high_active || sel_i.chip_select2_n))
      |=> st.last_op == SBSP_OP_IDLE)
    else $error("controller strobe while unselected did not deselect");

  a_ctrl_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (ctl_i.cpu_addr_strobe_n && !ctl_i.ctrl_addr_strobe_n && selected && any_wr)
      |=> st.last_op == SBSP_OP_WRITE)
    else $error("controller strobe with byte strobe low did not write");

  a_step_count: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (active && cont && !ctl_i.burst_step_n) |=> count == $past(count) + CNT_ONE)
    else $error("burst step did not advance the counter");

  a_suspend_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_suspend |=> $stable(st.upper) && $stable(cur_lsbs))
    else $error("address changed during a suspended cycle");

  a_interleave: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (s_cpu_start ##1 s_step) |=> cur_lsbs == ($past(addr_i[CNT_W-1:0], 2) ^ CNT_ONE))
    else $error("burst address is not start xor count");

  a_write_stored: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (op == SBSP_OP_WRITE && ctl_i.byte_write_strobes_n == 4'h0) |=> mem[$past(op_addr)] == $past(dq_i))
    else $error("write data was not stored");

  a_read_repeat: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (s_suspend ##0 (op == SBSP_OP_READ)) |=> dq_o == $past(mem[op_addr]))
    else $error("suspended read did not repeat the current word");

  a_cont_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (ctl_i.cpu_addr_strobe_n && ctl_i.ctrl_addr_strobe_n && active && any_wr) |=> st.last_op == SBSP_OP_WRITE)
    else $error("continue cycle with byte strobe low did not write");

  a_cpu_over_ctrl: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (s_cpu_start ##0 (!ctl_i.ctrl_addr_strobe_n && any_wr)) |=> st.last_op == SBSP_OP_READ)
    else $error("cpu strobe did not win over a controller write");

  a_load_count: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!ctl_i.ctrl_addr_strobe_n && selected) |=> count == CNT_RST)
    else $error("burst start did not clear the counter");

  a_read_drive: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (op == SBSP_OP_READ && ctl_i.byte_write_strobes_n == 4'hF && !out_enable_n_i) |=> dq_oe_o)
    else $error("enabled read did not drive the data outputs");

endmodule

/* File: hw/sbsp_pkg.sv */
package sbsp_pkg;

  localparam int unsigned ADDR_W  = 15;
  localparam int unsigned UPPER_W = 13;
  localparam int unsigned CNT_W   = 2;
  localparam int unsigned LANES   = 4;
  localparam int unsigned BYTE_W  = 9;
  localparam int unsigned DATA_W  = 36;
  localparam int unsigned DEPTH   = 32768;

  localparam logic [CNT_W-1:0]   CNT_RST   = 2'h0;
  localparam logic [CNT_W-1:0]   CNT_ONE   = 2'h1;
  localparam logic [UPPER_W-1:0] UPPER_RST = 13'h0000;
  localparam logic [DATA_W-1:0]  DATA_RST  = 36'h0_0000_0000;

  typedef enum logic [1:0] {
    SBSP_OP_IDLE  = 2'b00,
    SBSP_OP_READ  = 2'b01,
    SBSP_OP_WRITE = 2'b10
  } sbsp_op_e;

  // Synchronous control pins, all active low.
  typedef struct packed {
    logic             cpu_addr_strobe_n;
    logic             ctrl_addr_strobe_n;
    logic             burst_step_n;
    logic [LANES-1:0] byte_write_strobes_n;
  } sbsp_ctl_s;

  // Three chip selects: low, high and low active.
  typedef struct packed {
    logic chip_select_n;
    logic chip_select_high_active;
    logic chip_select2_n;
  } sbsp_sel_s;

  typedef struct packed {
    logic [CNT_W-1:0] start;
    logic [CNT_W-1:0] count;
  } sbsp_ctr_s;

  typedef struct packed {
    logic [UPPER_W-1:0] upper;
    sbsp_op_e           last_op;
    logic [DATA_W-1:0]  dq_out;
    logic               dq_oe;
  } sbsp_state_s;

endpackage

/* File: hw/sbsp_burst_ctr.sv */
`timescale 1ns/100ps
module sbsp_burst_ctr (
  input  wire logic                      clock_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      load_i,
  input  wire logic                      step_i,
  input  wire logic [sbsp_pkg::CNT_W-1:0] start_i,
  output logic      [sbsp_pkg::CNT_W-1:0] lsbs_o,
  output logic      [sbsp_pkg::CNT_W-1:0] count_o,
  output logic      [sbsp_pkg::CNT_W-1:0] next_lsbs_o
);
  import sbsp_pkg::*;

  sbsp_ctr_s st;
  sbsp_ctr_s next_st;

  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.start = start_i;
      next_st.count = CNT_RST;
    end else if (step_i) begin
      next_st.count = st.count + CNT_ONE;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '{start: CNT_RST, count: CNT_RST};
    end else begin
      st <= next_st;
    end
  end

  assign lsbs_o      = st.start ^ st.count;
  assign next_lsbs_o = next_st.start ^ next_st.count;
  assign count_o     = st.count;

endmodule

/* File: tb/sbsp_ctrl_model.sv */
`timescale 1ns/100ps
module sbsp_ctrl_model
  import sbsp_pkg::*;
(
  input  wire logic                        clock_i,
  output logic      [sbsp_pkg::ADDR_W-1:0] addr_o,
  output sbsp_pkg::sbsp_ctl_s              ctl_o,
  output sbsp_pkg::sbsp_sel_s              sel_o,
  output logic                             oe_n_o,
  output logic      [sbsp_pkg::DATA_W-1:0] dq_o
);
  initial begin
    ctl_o  = 7'h7F;
    sel_o  = 3'h2;
    addr_o = 15'h0000;
    oe_n_o = 1'b1;
    dq_o   = DATA_RST;
  end

  task automatic drive(input sbsp_ctl_s ctl, input sbsp_sel_s sel, input logic [ADDR_W-1:0] addr,
                       input logic [DATA_W-1:0] data, input logic oe_n);
    @(posedge clock_i);
    // Each request stands unchanged until the next edge.
    ctl_o  <= ctl;
    sel_o  <= sel;
    addr_o <= addr;
    oe_n_o <= oe_n;
    // Write data goes out with its strobes; a released bus shows the inverse.
    dq_o   <= (&ctl.byte_write_strobes_n) ? ~dq_o : data;
  endtask
endmodule

/* File: tb/sbsp_port_bench.sv */
`timescale 1ns/100ps
module sbsp_port_bench;
  import sbsp_pkg::*;
  localparam logic [ADDR_W-1:0] BASE   = 15'h1234;
  localparam logic [2:0]        SEL_ON = 3'h2;
  logic                clock_i   = 1'b0;
  logic                sys_rst_i = 1'b1;
  logic [ADDR_W-1:0]   addr;
  sbsp_ctl_s           ctl;
  sbsp_sel_s           sel;
  logic                oe_n;
  logic [DATA_W-1:0]   dq_i;
  logic [DATA_W-1:0]   dq_o;
  logic                dq_oe_o;
  int                  failures   = 0;
  int                  num_checks = 0;

  always #12.5 clock_i = ~clock_i;

  sbsp_ctrl_model ctrl_u (.clock_i(clock_i), .addr_o(addr), .ctl_o(ctl), .sel_o(sel), .oe_n_o(oe_n), .dq_o(dq_i));
  sbsp_port dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .ctl_i(ctl), .sel_i(sel),
                   .out_enable_n_i(oe_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));

  function automatic logic [DATA_W-1:0] word(input int k);
    return 36'h9_C3A5_0F00 + DATA_W'(k);
  endfunction

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input logic [6:0] c, input logic [2:0] s, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic o);
    ctrl_u.drive(c, s, a, d, o);
    #1;
  endtask

  task automatic chk_oe(input logic exp);
    chk("dq_oe_o", {35'h0, exp}, {35'h0, dq_oe_o});
  endtask

  task automatic chk_rd(input logic [DATA_W-1:0] exp);
    chk_oe(1'b1);
    chk("dq_o", exp, dq_o);
  endtask

  task automatic test_burst_order;
    cyc(7'h50, SEL_ON, BASE | 15'h1, word(0), 1'b0);
    for (int k = 1; k < 4; k++) begin
      cyc(7'h60, SEL_ON, BASE, word(k), 1'b0);
      chk_oe(1'b0);
    end
    cyc(7'h3F, SEL_ON, BASE, word(9), 1'b0);
    chk_oe(1'b0);
    for (int k = 0; k < 5; k++) begin
      cyc(7'h6F, SEL_ON, BASE, word(9), 1'b0);
      chk_rd(word((k % 4) ^ 1));
    end
  endtask

  task automatic test_cpu_ignores_bw;
    logic [DATA_W-1:0] exp;
    exp = word(0);
    exp[8:0] = 9'h0AB;
    cyc(7'h10, SEL_ON, BASE, word(7), 1'b0);
    cyc(7'h6E, SEL_ON, BASE, 36'h0_0000_00AB, 1'b0);
    chk_oe(1'b0);
    chk("dq_o", word(1), dq_o);
    cyc(7'h5F, SEL_ON, BASE | 15'h1, word(9), 1'b0);
    chk_oe(1'b0);
    cyc(7'h7F, SEL_ON, BASE, word(9), 1'b0);
    chk_rd(exp);
    cyc(7'h5F, SEL_ON, BASE, word(9), 1'b0);
    cyc(7'h7F, SEL_ON, BASE, word(9), 1'b0);
    chk_rd(word(1));
  endtask

  task automatic test_suspend;
    logic [DATA_W-1:0] mix;
    mix = word(2) & 36'hF_FFFC_0000;
    cyc(7'h3F, SEL_ON, BASE | 15'h2, word(9), 1'b0);
    cyc(7'h7F, SEL_ON, BASE, word(9), 1'b0);
    chk_rd(word(3));
    cyc(7'h7F, SEL_ON, BASE, word(9), 1'b0);
    chk_rd(word(3));
    cyc(7'h6F, SEL_ON, BASE, word(9), 1'b0);
    chk_rd(word(3));
    cyc(7'h7F, SEL_ON, BASE, word(9), 1'b0);
    chk_rd(word(2));
    cyc(7'h7C, SEL_ON, BASE, 36'h0_0000_0000, 1'b0);
    cyc(7'h7F, SEL_ON, BASE, word(9), 1'b0);
    chk_oe(1'b0);
    cyc(7'h7F, SEL_ON, BASE, word(9), 1'b0);
    chk_rd(mix);
  endtask

  task automatic test_select;
    logic [2:0] bad;
    for (int i = 0; i < 3; i++) begin
      bad = SEL_ON ^ (3'h4 >> i);
      cyc(7'h5F, bad, BASE, word(9), 1'b0);
      cyc(7'h3F, bad, BASE, word(9), 1'b0);
      chk_oe(1'b0);
      cyc(7'h7F, bad, BASE, word(9), 1'b0);
      chk_oe(1'b0);
    end
  endtask

  task automatic finish_test;
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge clock_i);
    chk_oe(1'b0);
    sys_rst_i <= 1'b0;
    test_burst_order();
    test_cpu_ignores_bw();
    test_suspend();
    test_select();
    finish_test();
  end
endmodule
